// [hdl/epi_defines.vh]
// epi_defines.vh: offsets, field positions, reset values and timing counts
// assumes: included by every design file of the external pin interrupt block
`ifndef EPI_DEFINES_VH
`define EPI_DEFINES_VH

// register offsets (byte addresses as printed)
`define EPI_ADDR_W          9
`define EPI_OFS_EXT_EN      9'h1FA
`define EPI_OFS_EXT_FILT    9'h1FC
`define EPI_OFS_KEY_EN      9'h1FE
`define EPI_OFS_CTRL        9'h1E0
`define EPI_OFS_IRQ_STAT    9'h1E4
`define EPI_OFS_IRQ_CLR     9'h1E8
`define EPI_OFS_IRQ_ENA     9'h1EC

// reset values
`define EPI_RST_BYTE        8'h00
`define EPI_RST_NIB         4'h0

// filter select codes
`define EPI_FILT_NONE       2'h0
`define EPI_FILT_F1         2'h1
`define EPI_FILT_F8         2'h2
`define EPI_FILT_F32        2'h3

// sampling dividers
`define EPI_DIV_W           5
`define EPI_DIV8_LAST       3'h7
`define EPI_DIV32_LAST      5'h1F
`define EPI_MATCH_COUNT     2'h3

// status bit layout: four external inputs, then the key event
`define EPI_STAT_W          5
`define EPI_STAT_KEY        4

`endif

// [hdl/epi_filter.v]
// epi_filter.v: digital noise filter for one external interrupt input
// assumes: level_in already synchronised; sample_en pulses once per sample
`timescale 1ns/100ps
`include "epi_defines.vh"

module epi_filter (
   // clock and reset
   input  wire clk_sys,
   input  wire rstn,
   // control
   input  wire bypass,
   input  wire sample_en,
   // level in and filtered level out
   input  wire level_in,
   output wire level_out
);

   reg       cand_r;
   reg [1:0] cnt_r;
   reg       out_r;

   // out follows level_in in bypass, otherwise changes only after three successive equal samples
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cand_r <= 1'b1;
         cnt_r  <= 2'h0;
         out_r  <= 1'b1;
      end else if (bypass) begin
         cand_r <= level_in;
         cnt_r  <= 2'h0;
         out_r  <= level_in;
      end else if (sample_en) begin
         if (level_in != cand_r) begin
            cand_r <= level_in;
            cnt_r  <= 2'h1;
         end else if (cnt_r != `EPI_MATCH_COUNT) begin
            cnt_r <= cnt_r + 2'h1;
            if (cnt_r + 2'h1 == `EPI_MATCH_COUNT)
               out_r <= level_in;
         end
      end
   end

   assign level_out = bypass ? level_in : out_r;

endmodule // epi_filter

// [hdl/epi_sync.v]
// epi_sync.v: two flip-flop synchroniser for one input pin
// assumes: pin is asynchronous to clk_sys; reset is asynchronous active low
`timescale 1ns/100ps
`include "epi_defines.vh"

module epi_sync (
   // clock and reset
   input  wire clk_sys,
   input  wire rstn,
   // pin and synchronised level
   input  wire pin_in,
   output wire level_out
);

   reg meta_r;
   reg sync_r;

   // meta_r is read only by sync_r
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
      end else begin
         meta_r <= pin_in;
         sync_r <= meta_r;
      end
   end

   assign level_out = sync_r;

endmodule // epi_sync

// [hdl/epi_top.v]
// epi_top.v: external pin and key input interrupt front end with registers
// assumes: single-cycle register port, read data one cycle after read strobe;
// edge-sense bits of the per-source control registers arrive as inputs
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "epi_defines.vh"

// Operation
// - each external input has an enable bit at an even position
// - odd bit above the enable picks one edge or both edges
// - rewriting the external enable register may raise a spurious request
// - two-bit filter code: none, undivided, divide by 8, divide by 32
// - filtered request only after three successive equal samples
// - any key pin active edge raises shared request and wake-up
// - each key pin has an enable bit at an even position
// - odd bit above key enable picks falling or rising edge
// - enabled key pin held active masks edges on other key pins
// - rewriting the key enable register may raise a spurious request
// - external edge depends on polarity bit and edge sense bit
module epi_top (
   // clock and reset
   input  wire                     clk_sys,
   input  wire                     rstn,
   // register port
   input  wire [`EPI_ADDR_W-1:0]   reg_addr,
   input  wire [7:0]               reg_wdata,
   input  wire                     reg_wr,
   input  wire                     reg_rd,
   output reg  [7:0]               reg_rdata,
   // pins
   input  wire [3:0]               external_irq_pin,
   input  wire [3:0]               key_pin,
   // edge sense bits of the per-source control registers, 1 = rising
   input  wire [3:0]               edge_sense_bit,
   // requests
   output reg  [3:0]               ext_request_flag,
   output reg                      key_request_flag,
   output reg                      key_wakeup,
   output reg                      irq
);

   // registers
   reg  [7:0]              ext_en_r;
   reg  [7:0]              ext_filt_r;
   reg  [7:0]              key_en_r;
   reg  [3:0]              ctrl_r;
   reg  [`EPI_STAT_W-1:0]  stat_r;
   reg  [`EPI_STAT_W-1:0]  ena_r;
   reg  [`EPI_DIV_W-1:0]   div_r;

   // synchronised and filtered levels
   wire [3:0] ext_sync;
   wire [3:0] ext_filt;
   wire [3:0] key_sync;
   reg  [3:0] ext_prev_r;
   reg  [3:0] key_prev_r;

   // spurious-request emulation toggles
   wire spur_ext_en = ctrl_r[0];
   wire spur_key_en = ctrl_r[1];

   // sampling strobes
   wire tick_f8  = (div_r[2:0] == `EPI_DIV8_LAST);
   wire tick_f32 = (div_r == `EPI_DIV32_LAST);

   function [1:0] fcode;
      input [7:0] filt;
      input integer idx;
      begin
         fcode = filt[2*idx +: 2];
      end
   endfunction

   function sample_pick;
      input [1:0] code;
      input       t8;
      input       t32;
      begin
         case (code)
            `EPI_FILT_F1:  sample_pick = 1'b1;
            `EPI_FILT_F8:  sample_pick = t8;
            `EPI_FILT_F32: sample_pick = t32;
            default:       sample_pick = 1'b0;
         endcase
      end
   endfunction

   function is_addr;
      input [`EPI_ADDR_W-1:0] a;
      input [`EPI_ADDR_W-1:0] ofs;
      begin
         is_addr = (a == ofs);
      end
   endfunction

   // sampling clock divider for f8 and f32
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         div_r <= {`EPI_DIV_W{1'b0}};
      else
         div_r <= div_r + {{(`EPI_DIV_W-1){1'b0}}, 1'b1};
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
         epi_sync u_ext_sync (
            .clk_sys   (clk_sys),
            .rstn      (rstn),
            .pin_in    (external_irq_pin[gi]),
            .level_out (ext_sync[gi])
         );
         epi_sync u_key_sync (
            .clk_sys   (clk_sys),
            .rstn      (rstn),
            .pin_in    (key_pin[gi]),
            .level_out (key_sync[gi])
         );
         epi_filter u_filter (
            .clk_sys   (clk_sys),
            .rstn      (rstn),
            .bypass    (fcode(ext_filt_r, gi) == `EPI_FILT_NONE),
            .sample_en (sample_pick(fcode(ext_filt_r, gi), tick_f8, tick_f32)),
            .level_in  (ext_sync[gi]),
            .level_out (ext_filt[gi])
         );
      end
   endgenerate

   // external edge detection
   reg [3:0] ext_edge;
   integer   i;
   always @* begin
      ext_edge = 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
         if (ext_en_r[2*i]) begin
            if (ext_en_r[2*i+1])
               ext_edge[i] = ext_filt[i] ^ ext_prev_r[i];
            else if (edge_sense_bit[i])
               ext_edge[i] = ext_filt[i] & ~ext_prev_r[i];
            else
               ext_edge[i] = ~ext_filt[i] & ext_prev_r[i];
         end
      end
   end
   // left to software: both-edge mode ignores edge_sense_bit here

   // key detection
   reg [3:0] key_act;
   reg [3:0] key_hit;
   reg       key_edge;
   integer   k;
   always @* begin
      key_act = 4'h0;
      key_hit = 4'h0;
      for (k = 0; k < 4; k = k + 1) begin
         if (key_en_r[2*k]) begin
            // active level: high for rising, low for falling
            key_act[k] = key_en_r[2*k+1] ? key_prev_r[k] : ~key_prev_r[k];
            key_hit[k] = key_en_r[2*k+1] ? (key_sync[k] & ~key_prev_r[k])
                                         : (~key_sync[k] & key_prev_r[k]);
         end
      end
      // a pin already held active blocks new edges on the others
      key_edge = |key_hit & ~(|key_act);
   end

   // register writes
   wire wr_ext_en  = reg_wr & is_addr(reg_addr, `EPI_OFS_EXT_EN);
   wire wr_key_en  = reg_wr & is_addr(reg_addr, `EPI_OFS_KEY_EN);
   wire wr_irq_clr = reg_wr & is_addr(reg_addr, `EPI_OFS_IRQ_CLR);

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ext_en_r   <= `EPI_RST_BYTE;
         ext_filt_r <= `EPI_RST_BYTE;
         key_en_r   <= `EPI_RST_BYTE;
         ctrl_r     <= `EPI_RST_NIB;
         ena_r      <= {`EPI_STAT_W{1'b0}};
      end else if (reg_wr) begin
         if (wr_ext_en)
            ext_en_r <= reg_wdata;
         if (is_addr(reg_addr, `EPI_OFS_EXT_FILT))
            ext_filt_r <= reg_wdata;
         if (wr_key_en)
            key_en_r <= reg_wdata;
         if (is_addr(reg_addr, `EPI_OFS_CTRL))
            ctrl_r <= reg_wdata[3:0];
         if (is_addr(reg_addr, `EPI_OFS_IRQ_ENA))
            ena_r <= reg_wdata[`EPI_STAT_W-1:0];
      end
   end

   // spurious request on enable-register rewrite, when emulation is on
   // all four flags at once: software cannot tell which input the rewrite disturbed
   wire [3:0] ext_spur = {4{wr_ext_en & spur_ext_en & (|reg_wdata)}};
   wire       key_spur = wr_key_en & spur_key_en;

   wire [3:0] ext_set = ext_edge | ext_spur;
   wire       key_set = key_edge | key_spur;
   wire [`EPI_STAT_W-1:0] stat_set = {key_set, ext_set};

   // sticky status, set wins over clear
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         stat_r     <= {`EPI_STAT_W{1'b0}};
         ext_prev_r <= 4'hF;
         key_prev_r <= 4'hF;
      end else begin
         stat_r <= (stat_r & ~({`EPI_STAT_W{wr_irq_clr}} & reg_wdata[`EPI_STAT_W-1:0]))
                   | stat_set;
         ext_prev_r <= ext_filt;
         key_prev_r <= key_sync;
      end
   end

   // outputs registered
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ext_request_flag <= 4'h0;
         key_request_flag <= 1'b0;
         key_wakeup       <= 1'b0;
         irq              <= 1'b0;
      end else begin
         ext_request_flag <= ext_set;
         key_request_flag <= key_set;
         key_wakeup       <= key_edge;
         irq              <= |((stat_r & ~({`EPI_STAT_W{wr_irq_clr}}
                                & reg_wdata[`EPI_STAT_W-1:0]) | stat_set) & ena_r);
      end
   end

   // read data one cycle after the strobe; unmapped reads zero
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         reg_rdata <= `EPI_RST_BYTE;
      else if (reg_rd) begin
         case (reg_addr)
            `EPI_OFS_EXT_EN:   reg_rdata <= ext_en_r;
            `EPI_OFS_EXT_FILT: reg_rdata <= ext_filt_r;
            `EPI_OFS_KEY_EN:   reg_rdata <= key_en_r;
            `EPI_OFS_CTRL:     reg_rdata <= {4'h0, ctrl_r};
            `EPI_OFS_IRQ_STAT: reg_rdata <= {3'h0, stat_r};
            `EPI_OFS_IRQ_ENA:  reg_rdata <= {3'h0, ena_r};
            default:           reg_rdata <= 8'h00;
         endcase
      end else
         reg_rdata <= 8'h00;
   end

endmodule // epi_top

// [tb/epi_pin_model.sv]
// epi_pin_model.sv: external and key pins as seen by the block
// assumes: bench sets the wanted levels; pins idle high by pull-up
`timescale 1ns/100ps
module epi_pin_model (
   // clock
   input  wire       clk_sys,
   // wanted levels
   input  wire [3:0] ext_lvl,
   input  wire [3:0] key_lvl,
   // pins
   output reg  [3:0] external_irq_pin,
   output reg  [3:0] key_pin
);
   initial begin
      external_irq_pin = 4'hF;
      key_pin = 4'hF;
   end
   // pins move mid-cycle, unrelated to the sampling edge
   always @(posedge clk_sys) begin
      external_irq_pin <= #17 ext_lvl;
      key_pin          <= #17 key_lvl;
   end
endmodule // epi_pin_model

// [tb/epi_top_monitor.sv]
// epi_top_monitor.sv: port checks for epi_top
// assumes: bound to epi_top; spurious requests only raised with all inputs enabled
`timescale 1ns/100ps
`include "epi_defines.vh"
module epi_top_monitor (
   // clock and reset
   input wire                   clk_sys,
   input wire                   rstn,
   // register port
   input wire [`EPI_ADDR_W-1:0] reg_addr,
   input wire [7:0]             reg_wdata,
   input wire                   reg_wr,
   input wire                   reg_rd,
   input wire [7:0]             reg_rdata,
   // pins and requests
   input wire [3:0]             external_irq_pin,
   input wire [3:0]             edge_sense_bit,
   input wire [3:0]             ext_request_flag,
   input wire                   key_request_flag,
   input wire                   key_wakeup,
   input wire                   irq
);
   reg [7:0] en_r;
   reg [7:0] filt_r;
   reg [7:0] ken_r;
   reg [7:0] ena_r;
   // shadow copies of the writable registers other than the control register
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         en_r   <= 8'h00;
         filt_r <= 8'h00;
         ken_r  <= 8'h00;
         ena_r  <= 8'h00;
      end else if (reg_wr) begin
         if (reg_addr == `EPI_OFS_EXT_EN) en_r <= reg_wdata;
         if (reg_addr == `EPI_OFS_EXT_FILT) filt_r <= reg_wdata;
         if (reg_addr == `EPI_OFS_KEY_EN) ken_r <= reg_wdata;
         if (reg_addr == `EPI_OFS_IRQ_ENA) ena_r <= reg_wdata;
      end
   end
   wire mode0 = en_r[1:0] == 2'h1 && filt_r[1:0] == 2'h0 && !edge_sense_bit[0];
   wire mode1 = en_r[3:2] == 2'h3 && filt_r[3:2] == 2'h0;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside answer cycle");
   a_ext_gated: assert property ((ext_request_flag & ~{en_r[6],en_r[4],en_r[2],en_r[0]}) == 4'h0)
      else $error("request from a disabled external input");
   a_bypass_fall: assert property (mode0 |-> ext_request_flag[0] ==
      ($past(external_irq_pin[0],4) && !$past(external_irq_pin[0],3)))
      else $error("bypassed falling edge request wrong");
   a_both_edge: assert property (mode1 |-> ext_request_flag[1] ==
      ($past(external_irq_pin[1],4) != $past(external_irq_pin[1],3)))
      else $error("both edge request wrong");
   a_key_gated: assert property (key_request_flag |-> (ken_r & 8'h55) != 8'h00)
      else $error("key request with no key pin enabled");
   a_wake_flag: assert property (key_wakeup |-> key_request_flag)
      else $error("wake-up without key request");
   a_key_pulse: assert property (key_request_flag |=> !key_request_flag)
      else $error("key request while a key is held active");
   a_irq_mask: assert property (ena_r == 8'h00 && $past(ena_r) == 8'h00 |-> !irq)
      else $error("irq high with all sources masked");
endmodule // epi_top_monitor

// [tb/tb.sv]
// tb.sv: self-checking bench for epi_top
// assumes: epi_top, epi_pin_model and epi_top_monitor compiled before
`timescale 1ns/100ps
`include "epi_defines.vh"
module tb;
   typedef struct packed {
      logic [2:0] idx;
      logic [7:0] en;
      logic [7:0] filt;
      logic [7:0] ken;
      logic [3:0] sns;
      logic [7:0] w;
      logic [1:0] ea;
      logic [1:0] eb;
   } epi_row_t;
   reg                   clk_sys, rstn, reg_wr, reg_rd;
   reg [`EPI_ADDR_W-1:0] reg_addr;
   reg [7:0]             reg_wdata, d8;
   reg [3:0]             edge_sense_bit, ext_lvl, key_lvl;
   wire [7:0]            reg_rdata;
   wire [3:0]            external_irq_pin, key_pin, ext_request_flag;
   wire                  key_request_flag, key_wakeup, irq;
   integer               n_errors, tests_run, i, na, nb, nw;
   integer               n_wake = 0;
   reg [8:0] ra [5] = '{`EPI_OFS_EXT_EN, `EPI_OFS_EXT_FILT, `EPI_OFS_KEY_EN,
                        `EPI_OFS_CTRL, `EPI_OFS_IRQ_ENA};
   // idx 0-3 external, 4-7 key; both-edge rows keep sense 0
   // short pulses last w+1 cycles: exactly two samples at f1, f8 and f32
   epi_row_t rows [14] = '{
      '{3'h0,8'h01,8'h00,8'h00,4'h0,8'hC8,2'h1,2'h0},
      '{3'h0,8'h01,8'h00,8'h00,4'hF,8'hC8,2'h0,2'h1},
      '{3'h0,8'h03,8'h00,8'h00,4'h0,8'hC8,2'h1,2'h1},
      '{3'h0,8'h00,8'h00,8'h00,4'h0,8'hC8,2'h0,2'h0},
      '{3'h3,8'h40,8'h00,8'h00,4'h0,8'hC8,2'h1,2'h0},
      '{3'h1,8'h0C,8'h00,8'h00,4'h0,8'hC8,2'h1,2'h1},
      '{3'h2,8'h10,8'h30,8'h00,4'h0,8'hC8,2'h1,2'h0},
      '{3'h0,8'h01,8'h01,8'h00,4'h0,8'h01,2'h0,2'h0},
      '{3'h0,8'h01,8'h02,8'h00,4'h0,8'h0F,2'h0,2'h0},
      '{3'h0,8'h01,8'h03,8'h00,4'h0,8'h3F,2'h0,2'h0},
      '{3'h4,8'h00,8'h00,8'h01,4'h0,8'hC8,2'h1,2'h0},
      '{3'h4,8'h00,8'h00,8'h03,4'h0,8'hC8,2'h0,2'h1},
      '{3'h4,8'h00,8'h00,8'h04,4'h0,8'hC8,2'h0,2'h0},
      '{3'h7,8'h00,8'h00,8'hC0,4'h0,8'hC8,2'h0,2'h1}};
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input [8:0] a, input [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task rd(input [8:0] a, output [7:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task lvl(input [2:0] idx, input v);
      @(posedge clk_sys);
      if (idx[2]) key_lvl[idx[1:0]] <= v;
      else ext_lvl[idx[1:0]] <= v;
   endtask
   // counts request pulses of one source over w cycles
   task phase(input integer w, input [2:0] idx, output integer n);
      n = 0;
      repeat (w) begin
         @(posedge clk_sys);
         #1 n = n + (idx[2] ? key_request_flag : ext_request_flag[idx[1:0]]);
      end
   endtask
   task regs_zero;
      integer k;
      for (k = 0; k < 5; k++) begin
         rd(ra[k], d8);
         chk("reset value", 8'h00, d8);
      end
   endtask
   task end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // wake-up pulses, counted at the edge that ends them
   always @(posedge clk_sys) begin
      if (key_wakeup === 1'b1)
         n_wake <= n_wake + 1;
   end
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      end_of_test;
   end
   initial begin
      {rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = 0;
      {edge_sense_bit, ext_lvl, key_lvl} = 12'h0FF;
      n_errors = 0;
      tests_run = 0;
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      regs_zero;
      rd(9'h100, d8);
      chk("unmapped read", 8'h00, d8);
      $display("test reset done");
      for (i = 0; i < 14; i++) begin
         wr(`EPI_OFS_EXT_EN, rows[i].en);
         wr(`EPI_OFS_EXT_FILT, rows[i].filt);
         wr(`EPI_OFS_KEY_EN, rows[i].ken);
         edge_sense_bit <= rows[i].sns;
         lvl(rows[i].idx, 1'b0);
         phase(rows[i].w, rows[i].idx, na);
         lvl(rows[i].idx, 1'b1);
         phase(200, rows[i].idx, nb);
         chk("requests while low", {6'h00, rows[i].ea}, 8'(na));
         chk("requests after release", {6'h00, rows[i].eb}, 8'(nb));
         $display("test row %0d done", i);
      end
      wr(`EPI_OFS_KEY_EN, 8'h05);
      nw = n_wake;
      lvl(3'h4, 1'b0);
      phase(20, 3'h4, na);
      chk("first key press", 8'h01, 8'(na));
      chk("key wake-up", 8'h01, 8'(n_wake - nw));
      lvl(3'h5, 1'b0);
      phase(20, 3'h4, na);
      lvl(3'h5, 1'b1);
      phase(20, 3'h4, nb);
      chk("masked key press", 8'h00, 8'(na + nb));
      chk("masked wake-up", 8'h01, 8'(n_wake - nw));
      lvl(3'h4, 1'b1);
      phase(20, 3'h4, nb);
      $display("test key masking done");
      wr(`EPI_OFS_IRQ_CLR, 8'h1F);
      wr(`EPI_OFS_EXT_EN, 8'h01);
      wr(`EPI_OFS_EXT_FILT, 8'h00);
      edge_sense_bit <= 4'h0;
      lvl(3'h0, 1'b0);
      phase(20, 3'h0, na);
      rd(`EPI_OFS_IRQ_STAT, d8);
      chk("status after edge", 8'h01, d8);
      chk("masked irq", 8'h00, {7'h00, irq});
      wr(`EPI_OFS_IRQ_ENA, 8'h01);
      phase(2, 3'h0, na);
      chk("irq raised", 8'h01, {7'h00, irq});
      wr(`EPI_OFS_IRQ_CLR, 8'h01);
      phase(2, 3'h0, na);
      chk("irq cleared", 8'h00, {7'h00, irq});
      rd(`EPI_OFS_IRQ_STAT, d8);
      chk("status cleared", 8'h00, d8);
      lvl(3'h0, 1'b1);
      $display("test interrupt done");
      phase(8, 3'h0, na);
      edge_sense_bit <= 4'hF;
      wr(`EPI_OFS_IRQ_CLR, 8'h1F);
      wr(`EPI_OFS_CTRL, 8'h03);
      wr(`EPI_OFS_EXT_EN, 8'h55);
      wr(`EPI_OFS_KEY_EN, 8'h05);
      rd(`EPI_OFS_IRQ_STAT, d8);
      chk("spurious requests", 8'h1F, d8);
      rd(`EPI_OFS_CTRL, d8);
      chk("spurious control", 8'h03, d8);
      $display("test spurious done");
      rstn <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      regs_zero;
      $display("test second reset done");
      end_of_test;
   end
   epi_top i_epi_top (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .external_irq_pin(external_irq_pin), .key_pin(key_pin),
      .edge_sense_bit(edge_sense_bit), .ext_request_flag(ext_request_flag),
      .key_request_flag(key_request_flag), .key_wakeup(key_wakeup), .irq(irq));
   epi_pin_model i_epi_pin_model (.clk_sys(clk_sys), .ext_lvl(ext_lvl), .key_lvl(key_lvl),
      .external_irq_pin(external_irq_pin), .key_pin(key_pin));
endmodule // tb
bind epi_top epi_top_monitor i_epi_top_monitor (.clk_sys(clk_sys), .rstn(rstn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .external_irq_pin(external_irq_pin),
   .edge_sense_bit(edge_sense_bit), .ext_request_flag(ext_request_flag),
   .key_request_flag(key_request_flag), .key_wakeup(key_wakeup), .irq(irq));
